/* common/dac_cmd_pkg.sv */
// constants for the quad converter serial command decoder
// assumes a 24-bit frame shifted in msb first on falling serial clock edges
// Function
// - two select bits pick channel A, B, C or D
// - flag set, mode 01: selected channel powered down via 1k to ground
// - flag set, mode 10: selected channel powered down via 100k to ground
// - flag set, mode 11: selected channel powered down, output high impedance
// - load code 10: write buffer, then update all four channels together
// - load code 01: write buffer, update only the selected channel
// - load code 00: write buffer only, no output or power change
// - load code 11, select 10: broadcast to all buffers and update all
// - updates apply only after the frame's 24th falling clock edge
// - reference frame with bits 01 forces reference always on
// - reference frame with bits 10 forces reference always off
// - reference frame with bits 00 restores automatic mode, as at reset
// - automatic mode: reference off once all four channels powered down
// - automatic mode: reference on when any channel returns to normal
// - flag clear means normal operation whatever the mode bits
// - power-down keeps the buffered code, and its update copies that code to the converter register
// - don't-care frame bits are ignored
package dac_cmd_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CODE_BITS = 14;
    localparam int NUM_CH = 4;
    localparam int BIT_LOAD_ALL = 21;
    localparam int BIT_LOAD_SINGLE = 20;
    localparam int BIT_SEL_HI = 18;
    localparam int BIT_SEL_LO = 17;
    localparam int BIT_PD_FLAG = 16;
    localparam int BIT_PD_MODE_HI = 15;
    localparam int BIT_PD_MODE_LO = 14;
    localparam int BIT_REF_HI = 13;
    localparam int BIT_REF_LO = 12;
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 2;
    localparam logic [1:0] SEL_BCAST = 2'h2;
    localparam logic [2:0] PD_NORMAL = 3'h0;
    localparam logic [4:0] CNT_LAST = 5'h17;
    localparam logic [CODE_BITS-1:0] CODE_RESET = 14'h0000;
    typedef enum logic [1:0] {
        REF_AUTO,
        REF_ON,
        REF_OFF
    } ref_mode_t;
endpackage

/* verilog/dac_sync2.sv */
// two-flop synchroniser for pin inputs
// assumes an asynchronous active-low reset
`timescale 1ns/1ps
module dac_sync2 (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pin and synchronised level
    input wire logic pin_in,
    output logic level_out
);
    logic meta_r;
    logic meta_nxt;
    logic level_r;
    logic level_nxt;

    // next values
    always_comb
    begin
        meta_nxt = pin_in;
        level_nxt = meta_r;
    end

    // registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_r <= 1'b0;
            level_r <= 1'b0;
        end
        else
        begin
            meta_r <= meta_nxt;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;
endmodule

/* verilog/dac_ch_store.sv */
// per-channel buffer and converter register store
// assumes one-cycle write and update strobes from the decoder
`timescale 1ns/1ps
module dac_ch_store (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // write side
    input wire logic [dac_cmd_pkg::NUM_CH-1:0] buf_we,
    input wire logic [dac_cmd_pkg::CODE_BITS-1:0] wr_code,
    input wire logic wr_is_pd,
    input wire logic [2:0] wr_pd,
    input wire logic [dac_cmd_pkg::NUM_CH-1:0] upd,
    // converter side
    output logic [dac_cmd_pkg::NUM_CH*dac_cmd_pkg::CODE_BITS-1:0] dac_code,
    output logic [dac_cmd_pkg::NUM_CH*3-1:0] dac_pd
);
    import dac_cmd_pkg::*;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic [CODE_BITS-1:0] bcode_r, bcode_nxt, dcode_r, dcode_nxt;
            logic [2:0] bpd_r, bpd_nxt, dpd_r, dpd_nxt;

            // buffer write, then update copies buffer into converter
            always_comb
            begin
                bcode_nxt = bcode_r;
                bpd_nxt = bpd_r;
                if (buf_we[g])
                begin
                    bpd_nxt = wr_pd;
                    if (!wr_is_pd)
                        bcode_nxt = wr_code;
                end
                dcode_nxt = dcode_r;
                dpd_nxt = dpd_r;
                if (upd[g])
                begin
                    dcode_nxt = bcode_nxt;
                    dpd_nxt = bpd_nxt;
                end
            end

            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    bcode_r <= CODE_RESET;
                    dcode_r <= CODE_RESET;
                    bpd_r <= PD_NORMAL;
                    dpd_r <= PD_NORMAL;
                end
                else
                begin
                    bcode_r <= bcode_nxt;
                    dcode_r <= dcode_nxt;
                    bpd_r <= bpd_nxt;
                    dpd_r <= dpd_nxt;
                end
            end

            assign dac_code[g*CODE_BITS +: CODE_BITS] = dcode_r;
            assign dac_pd[g*3 +: 3] = dpd_r;
        end
    endgenerate
endmodule

/* verilog/dac_cmd_decoder.sv */
// serial command decoder for a quad 14-bit converter
// assumes serial clock, data and active-low sync from a host, all async
`timescale 1ns/1ps
module dac_cmd_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // serial pins
    input wire logic sclk,
    input wire logic sdin,
    input wire logic sync_n,
    // converter outputs, channel A in the low slice
    output logic [dac_cmd_pkg::NUM_CH*dac_cmd_pkg::CODE_BITS-1:0] dac_code,
    output logic [dac_cmd_pkg::NUM_CH*3-1:0] dac_pd,
    // reference control
    output logic ref_enable,
    output dac_cmd_pkg::ref_mode_t ref_mode,
    // frame done pulse
    output logic frame_done
);
    import dac_cmd_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sclk_s, sdin_s, sync_s;

    dac_sync2 u_sync_sclk (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(sclk),
        .level_out(sclk_s)
    );
    dac_sync2 u_sync_sdin (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(sdin),
        .level_out(sdin_s)
    );
    dac_sync2 u_sync_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(sync_n),
        .level_out(sync_s)
    );

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    logic sclk_d_r, sclk_d_nxt;
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;
    logic fall;

    assign fall = sclk_d_r & ~sclk_s;

    // shift on falling edges while sync is low, msb first
    always_comb
    begin
        sclk_d_nxt = sclk_s;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (sync_s)
            cnt_nxt = '0; // sync high aborts a partial frame
        else if (fall)
        begin
            shift_nxt = {shift_r[FRAME_BITS-2:0], sdin_s};
            if (cnt_r == CNT_LAST)
            begin
                done_nxt = 1'b1;
                cnt_nxt = '0;
            end
            else
                cnt_nxt = cnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_d_r <= 1'b0;
            shift_r <= '0;
            cnt_r <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            sclk_d_r <= sclk_d_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign frame_done = done_r;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic ld_all, ld_one, pd_flag, is_ref_cmd, bcast;
    logic [1:0] sel;
    logic [2:0] pd_set;
    logic [CODE_BITS-1:0] code;
    logic [NUM_CH-1:0] buf_we, upd;

    // bits 23, 22, 19, 1, 0 are never looked at
    assign ld_all = shift_r[BIT_LOAD_ALL];
    assign ld_one = shift_r[BIT_LOAD_SINGLE];
    assign sel = {shift_r[BIT_SEL_HI], shift_r[BIT_SEL_LO]};
    assign pd_flag = shift_r[BIT_PD_FLAG];
    assign code = shift_r[CODE_MSB:CODE_LSB];
    // flag clear means normal, mode bits forced to zero
    assign pd_set = pd_flag ? {1'b1, shift_r[BIT_PD_MODE_HI],
        shift_r[BIT_PD_MODE_LO]} : PD_NORMAL;
    // reference control frame
    assign is_ref_cmd = pd_flag && !ld_all && !ld_one && sel == 2'h0
        && !shift_r[BIT_PD_MODE_HI] && !shift_r[BIT_PD_MODE_LO];
    assign bcast = ld_all && ld_one && sel == SEL_BCAST;

    // write and update strobes, fired on frame completion only
    always_comb
    begin
        buf_we = '0;
        upd = '0;
        if (done_r && !is_ref_cmd)
        begin
            if (bcast)
            begin
                buf_we = '1;
                upd = '1;
            end
            else if (!(ld_all && ld_one))
            begin
                buf_we[sel] = 1'b1;
                if (ld_all)
                    upd = '1;
                else if (ld_one)
                    upd[sel] = 1'b1;
            end
        end
    end

    dac_ch_store u_store (
        .clk(clk),
        .reset_n(reset_n),
        .buf_we(buf_we),
        .wr_code(code),
        .wr_is_pd(pd_flag),
        .wr_pd(pd_set),
        .upd(upd),
        .dac_code(dac_code),
        .dac_pd(dac_pd)
    );

    // ------------------------------------------------------------
    // reference control
    // ------------------------------------------------------------
    ref_mode_t mode_r, mode_nxt;
    logic ref_en_r, ref_en_nxt;
    logic all_pd;

    always_comb
    begin
        all_pd = 1'b1;
        for (int i = 0; i < NUM_CH; i++)
            all_pd = all_pd & dac_pd[i*3+2];
    end

    // mode from reference frames, enable follows mode or channel state
    always_comb
    begin
        mode_nxt = mode_r;
        if (done_r && is_ref_cmd)
        begin
            case ({shift_r[BIT_REF_HI], shift_r[BIT_REF_LO]})
                2'h1: mode_nxt = REF_ON;
                2'h2: mode_nxt = REF_OFF;
                2'h0: mode_nxt = REF_AUTO;
                default: mode_nxt = mode_r;
            endcase
        end
        case (mode_r)
            REF_ON: ref_en_nxt = 1'b1;
            REF_OFF: ref_en_nxt = 1'b0;
            default: ref_en_nxt = ~all_pd;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_r <= REF_AUTO;
            ref_en_r <= 1'b1;
        end
        else
        begin
            mode_r <= mode_nxt;
            ref_en_r <= ref_en_nxt;
        end
    end

    assign ref_enable = ref_en_r;
    assign ref_mode = mode_r;
endmodule

/* tb/dac_cmd_chk.sv */
// port checker for the quad converter command decoder
// assumes it is bound onto dac_cmd_decoder
`timescale 1ns/1ps
module dac_cmd_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // decoder outputs
    input wire logic [dac_cmd_pkg::NUM_CH*dac_cmd_pkg::CODE_BITS-1:0] dac_code,
    input wire logic [dac_cmd_pkg::NUM_CH*3-1:0] dac_pd,
    input wire logic ref_enable,
    input wire dac_cmd_pkg::ref_mode_t ref_mode,
    input wire logic frame_done
);
    import dac_cmd_pkg::*;
    logic all_pd;
    logic bad_pd;
    // all channels down, or a flag set with mode 00
    assign all_pd = dac_pd[2] & dac_pd[5] & dac_pd[8] & dac_pd[11];
    assign bad_pd = (dac_pd[2:0] == 3'h4) | (dac_pd[5:3] == 3'h4)
        | (dac_pd[8:6] == 3'h4) | (dac_pd[11:9] == 3'h4);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_code_after_done: assert property (dac_code != $past(dac_code) |->
        $past(frame_done)) else $error("code changed outside a frame");
    a_pd_after_done: assert property (dac_pd != $past(dac_pd) |->
        $past(frame_done)) else $error("power changed outside a frame");
    a_mode_after_done: assert property (ref_mode != $past(ref_mode) |->
        $past(frame_done)) else $error("ref mode changed alone");
    a_done_one_cycle: assert property (frame_done |=> !frame_done)
        else $error("frame done held");
    a_pd_code_legal: assert property (!bad_pd)
        else $error("illegal power setting");
    a_ref_forced_on: assert property ((ref_mode == REF_ON)[*2] |->
        ref_enable) else $error("reference off in on mode");
    a_ref_forced_off: assert property ((ref_mode == REF_OFF)[*2] |->
        !ref_enable) else $error("reference on in off mode");
    a_ref_auto_off: assert property ((ref_mode == REF_AUTO && all_pd)[*2]
        |-> !ref_enable) else $error("reference on, all down");
    a_ref_auto_on: assert property ((ref_mode == REF_AUTO && !all_pd)[*2]
        |-> ref_enable) else $error("reference off, channel up");
endmodule
bind dac_cmd_decoder dac_cmd_chk i_chk (.clk(clk), .reset_n(reset_n),
    .dac_code(dac_code), .dac_pd(dac_pd), .ref_enable(ref_enable),
    .ref_mode(ref_mode), .frame_done(frame_done));

/* tb/host_model.sv */
// serial host that sends 24-bit frames with an 80 ns serial clock
// assumes send is called just after a rising clk edge
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // serial pins
    output logic sclk,
    output logic sdin,
    output logic sync_n
);
    // idle: serial clock high and still, sync released
    initial
    begin
        sclk = 1'b1;
        sdin = 1'b0;
        sync_n = 1'b1;
    end
    // half of the serial clock period
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    // one frame, msb first, data settled before each falling edge
    task automatic send(input logic [23:0] f);
        sync_n <= 1'b0;
        half();
        for (int i = 23; i >= 0; i--)
        begin
            sdin <= f[i];
            sclk <= 1'b1;
            half();
            sclk <= 1'b0;
            half();
        end
        sclk <= 1'b1;
        sdin <= ~f[0];
        half();
        sync_n <= 1'b1;
        half();
    endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the quad converter command decoder
// assumes host_model drives the serial pins
`timescale 1ns/1ps
module tb;
    import dac_cmd_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sclk;
    logic sdin;
    logic sync_n;
    logic [NUM_CH*CODE_BITS-1:0] dac_code;
    logic [NUM_CH*3-1:0] dac_pd;
    logic ref_enable;
    ref_mode_t ref_mode;
    logic frame_done;
    int n_errors = 0;
    int total_checks = 0;
    int n_done = 0;
    logic [55:0] e_code = 56'h0;
    logic [11:0] e_pd = 12'h000;
    // clock and frame counting
    always #5 clk = ~clk;
    always @(posedge clk)
        if (frame_done === 1'b1) n_done <= n_done + 1;
    dac_cmd_decoder i_dut (.clk(clk), .reset_n(reset_n), .sclk(sclk),
        .sdin(sdin), .sync_n(sync_n), .dac_code(dac_code), .dac_pd(dac_pd),
        .ref_enable(ref_enable), .ref_mode(ref_mode),
        .frame_done(frame_done));
    host_model i_host (.clk(clk), .sclk(sclk), .sdin(sdin), .sync_n(sync_n));
    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [55:0] e,
        input logic [55:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    // frame bits 23, 22 and 19 always zero
    function automatic logic [23:0] mk(input logic [1:0] ld,
        input logic [1:0] sel, input logic flag, input logic [15:0] lo);
        return {2'h0, ld, 1'h0, sel, flag, lo};
    endfunction
    // send a frame and wait a bounded time for its done pulse
    task automatic frame(input logic [23:0] f);
        int n0;
        int k;
        n0 = n_done;
        i_host.send(f);
        k = 0;
        while (n_done == n0 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        if (n_done == n0)
        begin
            chk("frame_done count", 56'(n0 + 1), 56'(n_done));
            close_out();
        end
        else
            repeat (3) @(posedge clk);
    endtask
    task automatic outs();
        chk("dac_code", e_code, dac_code);
        chk("dac_pd", 56'(e_pd), 56'(dac_pd));
    endtask
    task automatic t_reset();
        outs();
        chk("ref_mode", 56'(REF_AUTO), 56'(ref_mode));
        chk("ref_enable", 56'h1, 56'(ref_enable));
        $display("test reset done");
    endtask
    task automatic t_buffered();
        frame(mk(2'h0, 2'h0, 1'h0, {14'h0A5C, 2'h3}));
        frame(mk(2'h0, 2'h1, 1'h0, {14'h1A5C, 2'h3}));
        frame(mk(2'h0, 2'h2, 1'h0, {14'h2A5C, 2'h3}));
        outs();
        frame(mk(2'h2, 2'h3, 1'h0, {14'h3FFE, 2'h0}));
        e_code = {14'h3FFE, 14'h2A5C, 14'h1A5C, 14'h0A5C};
        outs();
        $display("test buffered done");
    endtask
    task automatic t_single();
        frame(mk(2'h1, 2'h1, 1'h0, {14'h1234, 2'h0}));
        e_code[27:14] = 14'h1234;
        outs();
        frame(mk(2'h3, 2'h0, 1'h0, {14'h0001, 2'h3}));
        outs();
        $display("test single done");
    endtask
    task automatic t_pd();
        frame(mk(2'h1, 2'h0, 1'h1, 16'h7FFF));
        frame(mk(2'h1, 2'h1, 1'h1, 16'hBFFF));
        frame(mk(2'h0, 2'h2, 1'h1, 16'hFFFF));
        frame(mk(2'h2, 2'h3, 1'h1, 16'h7FFF));
        e_pd = {3'h5, 3'h7, 3'h6, 3'h5};
        outs();
        chk("ref_enable", 56'h0, 56'(ref_enable));
        frame(mk(2'h1, 2'h0, 1'h0, {14'h300F, 2'h3}));
        e_pd[2:0] = 3'h0;
        e_code[13:0] = 14'h300F;
        outs();
        chk("ref_enable", 56'h1, 56'(ref_enable));
        $display("test power-down done");
    endtask
    task automatic t_ref();
        frame(mk(2'h0, 2'h0, 1'h1, 16'h1FFF));
        chk("ref_mode", 56'(REF_ON), 56'(ref_mode));
        frame(mk(2'h3, 2'h2, 1'h1, 16'hFFFF));
        e_pd = 12'hFFF;
        outs();
        chk("ref_enable", 56'h1, 56'(ref_enable));
        frame(mk(2'h0, 2'h0, 1'h1, 16'h2FFF));
        chk("ref_mode", 56'(REF_OFF), 56'(ref_mode));
        frame(mk(2'h3, 2'h2, 1'h0, {14'h2AAA, 2'h3}));
        e_code = {4{14'h2AAA}};
        e_pd = 12'h000;
        outs();
        chk("ref_enable", 56'h0, 56'(ref_enable));
        frame(mk(2'h0, 2'h0, 1'h1, 16'h0FFF));
        chk("ref_mode", 56'(REF_AUTO), 56'(ref_mode));
        chk("ref_enable", 56'h1, 56'(ref_enable));
        $display("test reference done");
    endtask
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_buffered();
        t_single();
        t_pd();
        t_ref();
        close_out();
    end
endmodule
